// ===== include/wake_sleep_pkg.sv
package wake_sleep_pkg;
    // ***********************
    // timing
    // ***********************
    localparam int CLK_MHZ = 100;
    // power-on wait after rtc reset: 343.75 ms
    localparam int WAKE_NOTIFY_OUT_WAIT_US = 343750;
    localparam int WAKE_NOTIFY_OUT_WAIT_CYC = WAKE_NOTIFY_OUT_WAIT_US * CLK_MHZ;
    // ***********************
    // register map
    // ***********************
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_GPIO_EN = 4'h4;
    localparam logic [3:0] ADDR_WAIT = 4'h8;
    localparam logic [3:0] ADDR_DRAM = 4'hC;
    // status fields
    localparam int ST_BATT = 0;
    localparam int ST_GPIO = 1;
    localparam int ST_DCD = 2;
    // dram_sleep_ctrl fields
    localparam int DS_SRF_REQ = 0;
    localparam int DS_CLK_STOP = 1;
    localparam int DS_PIN_HOLD = 2;
    localparam int DS_SAFE = 3;
    localparam int DS_CTL_W = 3;
    // reset values
    localparam logic [15:0] GPIO_EN_RST = 16'h0000;
    localparam logic [2:0] DRAM_CTL_RST = 3'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    // synchroniser vector layout
    localparam int SYNC_W = 21;
    localparam int SY_DCD = 16;
    localparam int SY_ALARM = 17;
    localparam int SY_PSW = 18;
    localparam int SY_BATT = 19;
    localparam int SY_BDONE = 20;
    // idle levels: carrier_detect_n high, the rest low
    localparam logic [SYNC_W-1:0] SYNC_RST = 21'h01_0000;
    // ***********************
    // state types
    // ***********************
    typedef enum logic [1:0] {
        PS_OFF = 2'b00,
        PS_NOTIFY = 2'b01,
        PS_RUN = 2'b10
    } pwr_state_t;
    typedef enum logic [1:0] {
        MS_IDLE = 2'b00,
        MS_BURST = 2'b01,
        MS_ENTER = 2'b10
    } mem_state_t;
endpackage

// ===== logic/wake_sleep_ctrl.sv
// Operation
// - a gpio wake line wakes the core only when its enable bit is set
// - rtc reset clears every gpio wake enable bit
// - after notify, sample battery inhibit, then drop notify
// - battery inhibit high releases peripheral reset and starts cold reset
// - battery inhibit low sets its status flag and shuts down again
// - a gpio wake attempt sets the gpio wake flag either way
// - gpio line changes are ignored while notify is active
// - carrier detect assertion starts the same wake sequence
// - carrier detect status bit shows the live pin level
// - power switch masks carrier detect; compare level across switch
// - carrier detect changes are ignored while notify is active
// - elapsed timer alarm starts the wake sequence
// - alarm during notify is held and delivered afterwards, unless notify ends with the core running
// - dram sleep control register drives pins and reports status
// - self-refresh request runs burst refresh first when enabled
// - safe-to-gate bit means burst done and dram in self-refresh
// - clock gate bit stops the memory bus clock
// - pin hold bit latches dram interface signals
// - clearing pin hold returns pins to memory controller drive
// - notify lasts the wait time, 343.75 ms after rtc reset
//
// The implementer's own choices: register access over Wishbone and the register addresses.
module wake_sleep_ctrl #(
    parameter logic [31:0] WAIT_CYC = wake_sleep_pkg::WAKE_NOTIFY_OUT_WAIT_CYC
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // wake sources and power pins
    input wire logic [15:0] gpio_wake,
    input wire logic carrier_detect_n,
    input wire logic elapsed_timer_alarm,
    input wire logic power_switch,
    input wire logic battery_inhibit,
    input wire logic shutdown_req,
    output logic wake_notify_out,
    output logic periph_reset,
    output logic cold_reset_start,
    // memory controller side
    input wire logic burst_refresh_enable,
    input wire logic burst_refresh_done,
    input wire logic self_refresh_ack,
    output logic burst_refresh_req,
    output logic self_refresh_req,
    output logic mem_clk_stop,
    output logic dram_pin_hold
);
    import wake_sleep_pkg::*;

    // ***********************
    // input synchronisers
    // ***********************
    logic [SYNC_W-1:0] async_in;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;

    assign async_in = {burst_refresh_done, battery_inhibit, power_switch,
        elapsed_timer_alarm, carrier_detect_n, gpio_wake};

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            // idle levels, so no false carrier edge after reset
            sync1_q <= SYNC_RST;
            sync2_q <= SYNC_RST;
        end
        else if (ce)
        begin
            sync1_q <= async_in;
            sync2_q <= sync1_q;
        end
    end

    logic [15:0] gpio_lvl;
    logic dcd_lvl;
    logic alarm_lvl;
    logic psw_lvl;
    logic batt_lvl;
    logic bdone_lvl;
    logic srf_ack_s1_q;
    logic srf_ack_q;

    assign gpio_lvl = sync2_q[15:0];
    assign dcd_lvl = sync2_q[SY_DCD];
    assign alarm_lvl = sync2_q[SY_ALARM];
    assign psw_lvl = sync2_q[SY_PSW];
    assign batt_lvl = sync2_q[SY_BATT];
    assign bdone_lvl = sync2_q[SY_BDONE];

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            srf_ack_s1_q <= 1'b0;
            srf_ack_q <= 1'b0;
        end
        else if (ce)
        begin
            srf_ack_s1_q <= self_refresh_ack;
            srf_ack_q <= srf_ack_s1_q;
        end
    end

    // ***********************
    // registers and state
    // ***********************
    pwr_state_t state_q;
    pwr_state_t state_d;
    mem_state_t ms_q;
    mem_state_t ms_d;
    logic [31:0] wait_cnt_q;
    logic [31:0] wait_q;
    logic [15:0] gpio_en_q;
    logic [15:0] gpio_prev_q;
    logic dcd_ref_q;
    logic alarm_prev_q;
    logic alarm_pend_q;
    logic flag_batt_q;
    logic flag_gpio_q;
    logic [DS_CTL_W-1:0] dram_ctl_q;
    logic cold_q;
    logic ack_q;
    logic [31:0] rdata_q;

    // ***********************
    // wake event detection
    // ***********************
    logic notify_act;
    logic [15:0] gpio_rise;
    logic gpio_evt;
    logic dcd_evt;
    logic alarm_rise;
    logic wake_go;
    logic notify_end;

    assign notify_act = (state_q == PS_NOTIFY);
    assign gpio_rise = gpio_lvl & ~gpio_prev_q;
    // enabled lines only, masked while notifying
    assign gpio_evt = |(gpio_rise & gpio_en_q) && !notify_act;
    // reference level frozen while the power switch is held
    assign dcd_evt = !psw_lvl && !notify_act && !dcd_lvl
        && dcd_ref_q;
    assign alarm_rise = alarm_lvl && !alarm_prev_q;
    assign wake_go = (state_q == PS_OFF)
        && (gpio_evt || dcd_evt || alarm_pend_q);
    assign notify_end = notify_act && (wait_cnt_q == WORD_ZERO);

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            gpio_prev_q <= '0;
            dcd_ref_q <= 1'b1;
            alarm_prev_q <= 1'b0;
        end
        else if (ce)
        begin
            gpio_prev_q <= gpio_lvl;
            if (!psw_lvl)
            begin
                dcd_ref_q <= dcd_lvl;
            end
            alarm_prev_q <= alarm_lvl;
        end
    end

    // alarm held across notify, dropped once the core runs
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            alarm_pend_q <= 1'b0;
        end
        else if (ce)
        begin
            if (alarm_rise)
            begin
                alarm_pend_q <= 1'b1;
            end
            else if (wake_go || state_q == PS_RUN)
            begin
                alarm_pend_q <= 1'b0;
            end
        end
    end

    // ***********************
    // activation sequencer
    // ***********************
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            PS_OFF:
            begin
                if (wake_go)
                begin
                    state_d = PS_NOTIFY;
                end
            end
            PS_NOTIFY:
            begin
                if (notify_end)
                begin
                    state_d = batt_lvl ? PS_RUN : PS_OFF;
                end
            end
            PS_RUN:
            begin
                if (shutdown_req)
                begin
                    state_d = PS_OFF;
                end
            end
            default:
            begin
                state_d = PS_OFF;
            end
        endcase
    end

    logic [31:0] wait_load;

    assign wait_load = (wait_q == WORD_ZERO) ? WORD_ZERO
        : wait_q - 32'h0000_0001;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_q <= PS_OFF;
            wait_cnt_q <= WORD_ZERO;
            cold_q <= 1'b0;
        end
        else if (ce)
        begin
            state_q <= state_d;
            cold_q <= notify_end && batt_lvl;
            if (wake_go)
            begin
                wait_cnt_q <= wait_load;
            end
            else if (notify_act && !notify_end)
            begin
                wait_cnt_q <= wait_cnt_q - 32'h0000_0001;
            end
        end
    end

    assign wake_notify_out = notify_act;
    assign periph_reset = (state_q != PS_RUN);
    assign cold_reset_start = cold_q;

    // ***********************
    // dram self-refresh sequencer
    // ***********************
    logic safe_gate;

    always_comb
    begin
        ms_d = ms_q;
        case (ms_q)
            MS_IDLE:
            begin
                if (dram_ctl_q[DS_SRF_REQ])
                begin
                    ms_d = burst_refresh_enable ? MS_BURST
                        : MS_ENTER;
                end
            end
            MS_BURST:
            begin
                if (!dram_ctl_q[DS_SRF_REQ])
                begin
                    ms_d = MS_IDLE;
                end
                else if (bdone_lvl)
                begin
                    ms_d = MS_ENTER;
                end
            end
            MS_ENTER:
            begin
                if (!dram_ctl_q[DS_SRF_REQ])
                begin
                    ms_d = MS_IDLE;
                end
            end
            default:
            begin
                ms_d = MS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ms_q <= MS_IDLE;
        end
        else if (ce)
        begin
            ms_q <= ms_d;
        end
    end

    assign burst_refresh_req = (ms_q == MS_BURST);
    assign self_refresh_req = (ms_q == MS_ENTER);
    assign safe_gate = (ms_q == MS_ENTER) && srf_ack_q;
    assign mem_clk_stop = dram_ctl_q[DS_CLK_STOP];
    assign dram_pin_hold = dram_ctl_q[DS_PIN_HOLD];

    // ***********************
    // wishbone slave
    // ***********************
    logic req;
    logic wr;
    logic wr_status;
    logic wr_gpio_en;
    logic wr_wait;
    logic wr_dram;
    logic [31:0] status_rd;
    logic [31:0] dram_rd;
    logic [31:0] rd_mux;

    assign req = cyc_i && stb_i && !ack_q;
    // write lands on the edge that acknowledges it
    assign wr = cyc_i && stb_i && ack_q && we_i && sel_i[0];
    assign wr_status = wr && (adr_i == ADDR_STATUS);
    assign wr_gpio_en = wr && (adr_i == ADDR_GPIO_EN);
    assign wr_wait = wr && (adr_i == ADDR_WAIT);
    assign wr_dram = wr && (adr_i == ADDR_DRAM);

    assign status_rd = {29'h0, dcd_lvl, flag_gpio_q, flag_batt_q};
    assign dram_rd = {28'h0, safe_gate, dram_ctl_q};
    assign rd_mux = (adr_i == ADDR_STATUS) ? status_rd
        : (adr_i == ADDR_GPIO_EN) ? {16'h0, gpio_en_q}
        : (adr_i == ADDR_WAIT) ? wait_q
        : (adr_i == ADDR_DRAM) ? dram_rd
        : WORD_ZERO;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ack_q <= 1'b0;
            rdata_q <= WORD_ZERO;
        end
        else if (ce)
        begin
            ack_q <= req;
            rdata_q <= req ? rd_mux : WORD_ZERO;
        end
    end

    // no ack while frozen, so an acknowledged write is never lost
    assign ack_o = ack_q && ce;
    assign dat_o = rdata_q;

    // status flags: write one clears, a set in the same cycle wins
    logic clr_batt;
    logic clr_gpio;

    assign clr_batt = wr_status && dat_i[ST_BATT];
    assign clr_gpio = wr_status && dat_i[ST_GPIO];

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            flag_batt_q <= 1'b0;
            flag_gpio_q <= 1'b0;
        end
        else if (ce)
        begin
            flag_batt_q <= (notify_end && !batt_lvl)
                || (flag_batt_q && !clr_batt);
            flag_gpio_q <= (wake_go && gpio_evt)
                || (flag_gpio_q && !clr_gpio);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            gpio_en_q <= GPIO_EN_RST;
            wait_q <= WAIT_CYC;
            dram_ctl_q <= DRAM_CTL_RST;
        end
        else if (ce)
        begin
            if (wr_gpio_en)
            begin
                gpio_en_q <= dat_i[15:0];
            end
            if (wr_wait)
            begin
                wait_q <= dat_i;
            end
            if (wr_dram)
            begin
                dram_ctl_q <= dat_i[DS_CTL_W-1:0];
            end
        end
    end

    // ***********************
    // assertions
    // ***********************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_end_ok;
        ce && notify_end && batt_lvl;
    endsequence
    sequence s_end_low;
        ce && notify_end && !batt_lvl;
    endsequence
    sequence s_running;
        !wake_notify_out && !periph_reset && cold_reset_start;
    endsequence

    chk_wake_start: assert property (
        ce && wake_go |=> wake_notify_out)
        else $error("wake event did not raise notify");
    chk_gpio_gate: assert property (
        ce && state_q == PS_OFF && !dcd_evt && !alarm_pend_q
        && (gpio_rise & gpio_en_q) == 16'h0000 |=> !wake_notify_out)
        else $error("notify without enabled wake source");
    chk_en_reset: assert property (disable iff (1'b0)
        $fell(srst) |-> gpio_en_q == GPIO_EN_RST)
        else $error("gpio wake enables not cleared by reset");
    chk_batt_ok: assert property (
        s_end_ok |=> s_running)
        else $error("battery ok did not start cold reset");
    chk_batt_low: assert property (
        s_end_low |=> !wake_notify_out && periph_reset ##0 flag_batt_q)
        else $error("battery low did not flag and shut down");
    chk_gpio_flag: assert property (
        ce && wake_go && gpio_evt |=> flag_gpio_q [*2])
        else $error("gpio wake flag not set");
    chk_gpio_ignore: assert property (
        wake_notify_out |-> !gpio_evt)
        else $error("gpio change seen during notify");
    chk_dcd_live: assert property (
        $past(ce) && $past(ce, 2) && !$past(srst) && !$past(srst, 2)
        |-> status_rd[ST_DCD] == $past(carrier_detect_n, 2))
        else $error("carrier status not live");
    chk_dcd_switch: assert property (
        psw_lvl |-> !dcd_evt)
        else $error("carrier change seen under power switch");
    chk_dcd_ignore: assert property (
        wake_notify_out |-> !dcd_evt && !wake_go)
        else $error("carrier change seen during notify");
    chk_alarm_hold: assert property (
        ce && alarm_rise && wake_notify_out |=> alarm_pend_q)
        else $error("alarm during notify lost");
    chk_notify_hold: assert property (
        ce && wake_notify_out && !notify_end |=> wake_notify_out)
        else $error("notify dropped before wait elapsed");
    chk_srf_order: assert property (
        ce && ms_q == MS_IDLE && dram_ctl_q[DS_SRF_REQ]
        && burst_refresh_enable |=> burst_refresh_req && !self_refresh_req)
        else $error("self-refresh entered before burst refresh");
    chk_safe_gate: assert property (
        dram_rd[DS_SAFE] |-> self_refresh_req && srf_ack_q)
        else $error("safe-to-gate without self-refresh");
    chk_clk_pins: assert property (
        ce && wr_dram |=> mem_clk_stop == $past(dat_i[DS_CLK_STOP])
        && dram_pin_hold == $past(dat_i[DS_PIN_HOLD]))
        else $error("dram control write not applied");

endmodule // wake_sleep_ctrl

// ===== verification/mem_ctrl_model.sv
module mem_ctrl_model (
    input wire logic ref_clk,
    input wire logic slow,
    input wire logic [9:0] refresh_interval_reg,
    input wire logic [15:0] peripheral_clock_mask,
    input wire logic burst_refresh_req,
    input wire logic self_refresh_req,
    output logic burst_refresh_done,
    output logic self_refresh_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    int burst_cnt = 0;
    int srf_cnt = 0;
    logic sw_ready;
    // self-refresh only after software has prepared the controller
    assign sw_ready = (refresh_interval_reg == 10'h3FF)
        && (peripheral_clock_mask == 16'h0000);
    initial
    begin
        burst_refresh_done = 1'b0;
        self_refresh_ack = 1'b0;
    end
    // ***********************
    // burst then self-refresh
    // ***********************
    always @(posedge ref_clk)
    begin
        burst_cnt <= burst_refresh_req ? burst_cnt + 1 : 0;
        srf_cnt <= self_refresh_req ? srf_cnt + 1 : 0;
        // done only once the burst has run its length
        burst_refresh_done <= burst_refresh_req
            && burst_cnt >= (slow ? 12 : 1);
        // ack drops as soon as the request is withdrawn
        self_refresh_ack <= self_refresh_req && sw_ready
            && srf_cnt >= (slow ? 9 : 1);
    end
endmodule // mem_ctrl_model

// ===== verification/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import wake_sleep_pkg::*;
    localparam logic [31:0] WCYC = 32'h0000_0008;
    logic ref_clk = 1'b0, srst = 1'b1, ce = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
    logic [31:0] dat_i = WORD_ZERO, dat_o, rd;
    logic [15:0] gpio_wake = 16'h0000;
    logic carrier_detect_n = 1'b1, elapsed_timer_alarm = 1'b0;
    logic power_switch = 1'b0, battery_inhibit = 1'b1, shutdown_req = 1'b0;
    logic burst_refresh_enable = 1'b0, slow = 1'b0;
    logic [9:0] refresh_interval_reg = 10'h000;
    logic [15:0] peripheral_clock_mask = 16'hFFFF;
    logic ack_o, wake_notify_out, periph_reset, cold_reset_start;
    logic burst_refresh_done, self_refresh_ack, burst_refresh_req;
    logic self_refresh_req, mem_clk_stop, dram_pin_hold;
    int num_errors = 0, samples_checked = 0, cycles = 0;
    int idx, exp_en, exp_st;
    logic [31:0] dram_tab [4] = '{32'h3, 32'h7, 32'h3, 32'h0};
    always #5 ref_clk = ~ref_clk;
    wake_sleep_ctrl #(.WAIT_CYC(WCYC)) DUT (.ref_clk, .srst, .ce, .cyc_i,
        .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .gpio_wake,
        .carrier_detect_n, .elapsed_timer_alarm, .power_switch,
        .battery_inhibit, .shutdown_req, .wake_notify_out, .periph_reset,
        .cold_reset_start, .burst_refresh_enable, .burst_refresh_done,
        .self_refresh_ack, .burst_refresh_req, .self_refresh_req,
        .mem_clk_stop, .dram_pin_hold);
    mem_ctrl_model MEM (.ref_clk, .slow, .refresh_interval_reg,
        .peripheral_clock_mask, .burst_refresh_req,
        .self_refresh_req, .burst_refresh_done, .self_refresh_ack);
    // ***********************
    // helpers
    // ***********************
    task automatic give_verdict;
        $display("mismatches %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (exp !== got)
        begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // one wishbone classic cycle, entered just after a rising edge
    task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do @(posedge ref_clk); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rdchk(string what, logic [3:0] a, logic [31:0] e);
        bus(1'b0, a, WORD_ZERO);
        check(what, e, rd);
    endtask
    task automatic quiet(string what);
        logic hi;
        hi = 1'b0;
        repeat (30)
        begin
            @(posedge ref_clk);
            hi = hi | wake_notify_out;
        end
        check(what, 32'h0, hi);
    endtask
    // notify width and outcome of one activation
    task automatic wake(logic ok);
        int n;
        logic c;
        n = 0;
        repeat (40) if (wake_notify_out !== 1'b1) @(negedge ref_clk);
        check("notify rise", 32'h1, wake_notify_out);
        while (wake_notify_out === 1'b1 && n < 100)
        begin
            @(negedge ref_clk);
            n++;
        end
        check("notify width", WCYC, n);
        c = cold_reset_start;
        @(negedge ref_clk);
        c = c | cold_reset_start;
        check("cold reset pulse", ok, c);
        check("periph reset", !ok, periph_reset);
        @(posedge ref_clk);
    endtask
    task automatic off;
        shutdown_req <= 1'b1;
        @(posedge ref_clk);
        shutdown_req <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic dram(logic burst);
        int t;
        logic b;
        t = 0;
        b = 1'b0;
        bus(1'b1, ADDR_DRAM, 32'h1);
        while (self_refresh_ack !== 1'b1 && t < 200)
        begin
            @(posedge ref_clk);
            b = b | burst_refresh_req;
            t++;
        end
        check("burst request", burst, b);
        repeat (3) @(posedge ref_clk);
        rdchk("safe to gate", ADDR_DRAM, 32'h9);
    endtask
    // ***********************
    // main sequence
    // ***********************
    initial
    begin
        void'($urandom(19781));
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        exp_st = 32'h4;
        rdchk("status", ADDR_STATUS, exp_st);
        rdchk("gpio enable", ADDR_GPIO_EN, GPIO_EN_RST);
        rdchk("wait", ADDR_WAIT, WCYC);
        rdchk("dram ctl", ADDR_DRAM, WORD_ZERO);
        rdchk("unmapped", 4'h2, WORD_ZERO);
        gpio_wake <= 16'h0001;
        quiet("notify, line disabled");
        gpio_wake <= 16'h0000;
        idx = $urandom % 16;
        exp_en = 1 << idx;
        bus(1'b1, ADDR_GPIO_EN, exp_en);
        rdchk("gpio enable", ADDR_GPIO_EN, exp_en);
        battery_inhibit <= 1'b0;
        gpio_wake[idx] <= 1'b1;
        fork
            wake(1'b0);
            begin
                @(posedge wake_notify_out);
                @(posedge ref_clk);
                gpio_wake[idx] <= 1'b0;
                carrier_detect_n <= 1'b0;
                @(posedge ref_clk);
                gpio_wake[idx] <= 1'b1;
                carrier_detect_n <= 1'b1;
            end
        join
        quiet("notify after ignored changes");
        exp_st = exp_st | 32'h3;
        rdchk("status flags", ADDR_STATUS, exp_st);
        bus(1'b1, ADDR_STATUS, 32'h3);
        exp_st = 32'h4;
        rdchk("flags cleared", ADDR_STATUS, exp_st);
        gpio_wake <= 16'h0000;
        carrier_detect_n <= 1'b0;
        fork
            begin
                wake(1'b0);
                wake(1'b0);
            end
            begin
                @(posedge wake_notify_out);
                @(posedge ref_clk);
                elapsed_timer_alarm <= 1'b1;
                repeat (3) @(posedge ref_clk);
                elapsed_timer_alarm <= 1'b0;
            end
        join
        rdchk("carrier level", ADDR_STATUS, 32'h1);
        carrier_detect_n <= 1'b1;
        battery_inhibit <= 1'b1;
        repeat (6) @(posedge ref_clk);
        carrier_detect_n <= 1'b0;
        wake(1'b1);
        off();
        carrier_detect_n <= 1'b1;
        elapsed_timer_alarm <= 1'b1;
        wake(1'b1);
        elapsed_timer_alarm <= 1'b0;
        off();
        power_switch <= 1'b1;
        repeat (5) @(posedge ref_clk);
        carrier_detect_n <= 1'b0;
        quiet("notify, switch held");
        carrier_detect_n <= 1'b1;
        repeat (5) @(posedge ref_clk);
        power_switch <= 1'b0;
        quiet("notify, level unchanged");
        power_switch <= 1'b1;
        repeat (5) @(posedge ref_clk);
        carrier_detect_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        power_switch <= 1'b0;
        wake(1'b1);
        off();
        carrier_detect_n <= 1'b1;
        ce <= 1'b0;
        gpio_wake[idx] <= 1'b1;
        quiet("notify, clock held");
        ce <= 1'b1;
        wake(1'b1);
        off();
        refresh_interval_reg <= 10'h3FF;
        peripheral_clock_mask <= 16'h0000;
        burst_refresh_enable <= 1'b1;
        slow <= 1'b1;
        dram(1'b1);
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, ADDR_DRAM, dram_tab[i]);
            check("clock stop", dram_tab[i][1], mem_clk_stop);
            check("pin hold", dram_tab[i][2], dram_pin_hold);
        end
        repeat (4) @(posedge ref_clk);
        rdchk("dram idle", ADDR_DRAM, WORD_ZERO);
        burst_refresh_enable <= 1'b0;
        slow <= 1'b0;
        dram(1'b0);
        srst <= 1'b1;
        @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        rdchk("gpio enable", ADDR_GPIO_EN, GPIO_EN_RST);
        rdchk("dram ctl", ADDR_DRAM, WORD_ZERO);
        give_verdict();
    end
endmodule // tb_top
